//--- nvmc_defs.svh
// Function
// - 256-byte data array addressed by low address.
// - Code access uses 14-bit data, 15-bit address.
// - High address supplies upper code address bits.
// - Space select picks array; reset selects data.
// - Start bits set-only, cleared by hardware.
// - Write permit reset only at power-up, not by reset.
// - Reset during write sets abort flag.
// - Write completion clears start, sets done flag.
// - Unlock register always reads zero.
// - Data read lands in next cycle.
// - Low data holds until read or write.
// - Byte write erases then programs, self-timed.
// - Write needs 55h then AAh then start.
// - Start blocked while write permit clear.
// - Clearing permit never stops running write.
// - No data writes during power-up timer.
// - Code reads always; writes only unlocked blocks.
// - Code protection denies programmer, not CPU.
// - CPU data reads ignore data protect fuse.
// - Code fetch in second cycle after start.
`ifndef NVMC_DEFS_SVH
`define NVMC_DEFS_SVH
`define NVMC_A_ADRL 3'h0
`define NVMC_A_ADRH 3'h1
`define NVMC_A_DATL 3'h2
`define NVMC_A_DATH 3'h3
`define NVMC_A_CTRL 3'h4
`define NVMC_A_UNLK 3'h5
`define NVMC_A_FLAG 3'h6
`define NVMC_B_RD 0
`define NVMC_B_WR 1
`define NVMC_B_PERMIT 2
`define NVMC_B_ABORT 3
`define NVMC_B_FUSE 6
`define NVMC_B_CODE 7
`define NVMC_B_DONE 0
`define NVMC_KEY1 8'h55
`define NVMC_KEY2 8'hAA
`define NVMC_ERASED 8'hFF
`define NVMC_CODE_ERASED 14'h3FFF
`define NVMC_CLK_MHZ 50
`define NVMC_PWRT_MS 64
`define NVMC_WR_CYC 1000
`define NVMC_LOCK_NONE 2'h3
`define NVMC_LOCK_LOW 2'h2
`define NVMC_LOCK_HALF 2'h1
`define NVMC_LOCK_LOW_TOP 15'h0200
`define NVMC_LOCK_HALF_TOP 15'h4000
`endif

//--- nvmc_pkg.sv
package nvmc_pkg;
  typedef enum logic [2:0] {ST_IDLE, ST_ERASE, ST_PROG, ST_FWAIT, ST_FETCH} nvmc_state_e;
  typedef enum logic [1:0] {UL_IDLE, UL_55, UL_AA} nvmc_unlock_e;
endpackage

//--- nvmc_top.sv
`include "nvmc_defs.svh"
module nvmc_top #(
  parameter int PWRT_CYCLES = `NVMC_PWRT_MS * 1000 * `NVMC_CLK_MHZ,
  parameter int WR_CYCLES   = `NVMC_WR_CYC,
  parameter int EE_DEPTH    = 256
) (
  input  wire logic        clk_i,
  input  wire logic        por_b_i,
  input  wire logic        rst_b_i,
  input  wire logic [2:0]  reg_addr_i,
  input  wire logic [7:0]  reg_wdata_i,
  input  wire logic        reg_we_i,
  input  wire logic        reg_re_i,
  output logic      [7:0]  reg_rdata_o,
  input  wire logic [1:0]  self_program_lock_i,
  input  wire logic        data_protect_fuse_b_i,
  input  wire logic        code_protect_b_i,
  input  wire logic        ext_data_req_i,
  input  wire logic        ext_code_req_i,
  output logic             ext_data_grant_o,
  output logic             ext_code_grant_o,
  input  wire logic [13:0] prog_rdata_i,
  output logic      [14:0] prog_addr_o,
  output logic      [13:0] prog_wdata_o,
  output logic             prog_rd_o,
  output logic             prog_erase_o,
  output logic             prog_we_o,
  output logic             cpu_ignore_o,
  output logic             busy_o,
  output logic             store_done_flag_o
);
  import nvmc_pkg::*;

  localparam logic [21:0] PWRT_LIM = 22'(PWRT_CYCLES);
  localparam logic [15:0] WR_LIM   = 16'(WR_CYCLES - 1);

  function automatic logic hit(input logic [2:0] a, input logic [2:0] o);
    hit = (a == o);
  endfunction

  function automatic logic is_locked(input logic [1:0] lk, input logic [14:0] a);
    case (lk)
      `NVMC_LOCK_NONE: is_locked = 1'b0;
      `NVMC_LOCK_LOW:  is_locked = (a < `NVMC_LOCK_LOW_TOP);
      `NVMC_LOCK_HALF: is_locked = (a < `NVMC_LOCK_HALF_TOP);
      default:         is_locked = 1'b1;
    endcase
  endfunction

  nvmc_state_e  st_q, st_d;
  nvmc_unlock_e unlock_q, unlock_d;
  logic [15:0]  cnt_q, cnt_d;
  logic [21:0]  pwrt_q, pwrt_d;
  logic [7:0]   adrl_q, adrl_d, datl_q, datl_d, rdata_q, rd_mux;
  logic [6:0]   adrh_q, adrh_d;
  logic [5:0]   dath_q, dath_d;
  logic         code_q, code_d, fuse_q, fuse_d;
  logic         permit_q, permit_d, abort_q, abort_d, wip_q, wip_d;
  logic         rd_q, rd_d, wr_q, wr_d, done_q, done_d;
  logic         tcode_q;
  logic [14:0]  taddr_q;
  logic [13:0]  tdata_q;
  logic         perase_q, pwe_q;
  logic [7:0]   ee_mem [EE_DEPTH];

  wire         acc       = reg_we_i | reg_re_i;
  wire         ctl_wr    = reg_we_i & hit(reg_addr_i, `NVMC_A_CTRL);
  wire         unl_wr    = reg_we_i & hit(reg_addr_i, `NVMC_A_UNLK);
  wire         flag_wr   = reg_we_i & hit(reg_addr_i, `NVMC_A_FLAG);
  wire         idle      = (st_q == ST_IDLE);
  wire [14:0]  code_addr = {adrh_q, adrl_q};
  wire [7:0]   ee_rd_byte = ee_mem[adrl_q];
  wire         pwrt_on   = (pwrt_q != PWRT_LIM);
  wire         phase_end = (cnt_q == 16'h0000);
  wire         erase_end = (st_q == ST_ERASE) & phase_end;
  wire         prog_end  = (st_q == ST_PROG) & phase_end;
  wire         fetch_end = (st_q == ST_FETCH);
  wire         locked    = is_locked(self_program_lock_i, code_addr);
  wire         abort_set = wip_q & idle;

  // Permit and unlock are sampled from the current state, so a single write cannot arm itself.
  wire wr_go = ctl_wr & reg_wdata_i[`NVMC_B_WR] & idle & ~fuse_q
             & permit_q
             & (unlock_q == UL_AA)
             & (code_q ? ~locked : ~pwrt_on);
  wire rd_req     = ctl_wr & reg_wdata_i[`NVMC_B_RD] & ~reg_wdata_i[`NVMC_B_WR] & idle & ~fuse_q;
  wire ee_rd_go   = rd_req & ~code_q;
  wire code_rd_go = rd_req & code_q;

  assign unlock_d = (unl_wr & (reg_wdata_i == `NVMC_KEY1)) ? UL_55 :
                    (unl_wr & (reg_wdata_i == `NVMC_KEY2) & (unlock_q == UL_55)) ? UL_AA :
                    acc ? UL_IDLE : unlock_q;

  always_comb begin
    st_d = st_q;
    case (st_q)
      ST_IDLE: begin
        if (wr_go) begin
          st_d = ST_ERASE;
        end else if (code_rd_go) begin
          st_d = ST_FWAIT;
        end
      end
      ST_FWAIT: st_d = ST_FETCH;
      ST_FETCH: st_d = ST_IDLE;
      ST_ERASE: begin
        if (phase_end) begin
          st_d = ST_PROG;
        end
      end
      ST_PROG: begin
        if (phase_end) begin
          st_d = ST_IDLE;
        end
      end
      default: st_d = ST_IDLE;
    endcase
  end

  assign cnt_d = (wr_go | erase_end) ? WR_LIM : (phase_end ? cnt_q : cnt_q - 16'h0001);

  assign adrl_d = (reg_we_i & hit(reg_addr_i, `NVMC_A_ADRL)) ? reg_wdata_i : adrl_q;
  assign adrh_d = (reg_we_i & hit(reg_addr_i, `NVMC_A_ADRH)) ? reg_wdata_i[6:0] : adrh_q;
  assign datl_d = ee_rd_go ? ee_rd_byte : fetch_end ? prog_rdata_i[7:0] :
                  (reg_we_i & hit(reg_addr_i, `NVMC_A_DATL)) ? reg_wdata_i : datl_q;
  assign dath_d = fetch_end ? prog_rdata_i[13:8] :
                  (reg_we_i & hit(reg_addr_i, `NVMC_A_DATH)) ? reg_wdata_i[5:0] : dath_q;
  assign code_d = ctl_wr ? reg_wdata_i[`NVMC_B_CODE] : code_q;
  assign fuse_d = ctl_wr ? reg_wdata_i[`NVMC_B_FUSE] : fuse_q;
  assign rd_d   = code_rd_go | (rd_q & ~fetch_end);
  assign wr_d   = wr_go | (wr_q & ~prog_end);
  assign done_d = prog_end | (flag_wr ? reg_wdata_i[`NVMC_B_DONE] : done_q);
  assign permit_d = ctl_wr ? reg_wdata_i[`NVMC_B_PERMIT] : permit_q;
  assign abort_d = abort_set | (ctl_wr ? reg_wdata_i[`NVMC_B_ABORT] : abort_q);
  assign wip_d   = wr_go | (wip_q & ~prog_end & ~abort_set);
  assign pwrt_d  = pwrt_on ? pwrt_q + 22'h000001 : pwrt_q;

  assign rd_mux = hit(reg_addr_i, `NVMC_A_ADRL) ? adrl_q :
                  hit(reg_addr_i, `NVMC_A_ADRH) ? {1'b0, adrh_q} :
                  hit(reg_addr_i, `NVMC_A_DATL) ? datl_q :
                  hit(reg_addr_i, `NVMC_A_DATH) ? {2'h0, dath_q} :
                  hit(reg_addr_i, `NVMC_A_CTRL) ? {code_q, fuse_q, 2'h0, abort_q, permit_q, wr_q, rd_q} :
                  hit(reg_addr_i, `NVMC_A_FLAG) ? {7'h00, done_q} : 8'h00;

  // Power-up state survives ordinary resets so an interrupted write stays visible.
  always_ff @(posedge clk_i or negedge por_b_i) begin
    if (!por_b_i) begin
      permit_q <= 1'b0;
      abort_q  <= 1'b0;
      wip_q    <= 1'b0;
      pwrt_q   <= 22'h000000;
    end else begin
      permit_q <= permit_d;
      abort_q  <= abort_d;
      wip_q    <= wip_d;
      pwrt_q   <= pwrt_d;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_q     <= ST_IDLE;
      unlock_q <= UL_IDLE;
      cnt_q    <= 16'h0000;
      adrl_q   <= 8'h00;
      adrh_q   <= 7'h00;
      datl_q   <= 8'h00;
      dath_q   <= 6'h00;
      code_q   <= 1'b0;
      fuse_q   <= 1'b0;
      rd_q     <= 1'b0;
      wr_q     <= 1'b0;
      done_q   <= 1'b0;
      rdata_q  <= 8'h00;
    end else begin
      st_q     <= st_d;
      unlock_q <= unlock_d;
      cnt_q    <= cnt_d;
      adrl_q   <= adrl_d;
      adrh_q   <= adrh_d;
      datl_q   <= datl_d;
      dath_q   <= dath_d;
      code_q   <= code_d;
      fuse_q   <= fuse_d;
      rd_q     <= rd_d;
      wr_q     <= wr_d;
      done_q   <= done_d;
      rdata_q  <= reg_re_i ? rd_mux : 8'h00;
    end
  end

  // The target is frozen at start so later register writes cannot redirect a running write.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tcode_q  <= 1'b0;
      taddr_q  <= 15'h0000;
      tdata_q  <= 14'h0000;
      perase_q <= 1'b0;
      pwe_q    <= 1'b0;
    end else begin
      if (wr_go) begin
        tcode_q <= code_q;
        taddr_q <= code_q ? code_addr : {7'h00, adrl_q};
        tdata_q <= {dath_q, datl_q};
      end
      perase_q <= erase_end & tcode_q;
      pwe_q    <= prog_end & tcode_q;
    end
  end

  // Array contents are nonvolatile and therefore have no reset.
  always_ff @(posedge clk_i) begin
    if ((erase_end | prog_end) & ~tcode_q) begin
      ee_mem[taddr_q[7:0]] <= erase_end ? `NVMC_ERASED : tdata_q[7:0];
    end
  end

  // The frozen target shows only during a code write and its last pulse; later fetches use their own address.
  wire         code_wr_on = tcode_q & (wip_q | pwe_q);

  assign reg_rdata_o       = rdata_q;
  assign prog_addr_o       = code_wr_on ? taddr_q : code_addr;
  assign prog_wdata_o      = code_wr_on ? tdata_q : `NVMC_CODE_ERASED;
  assign prog_rd_o         = fetch_end;
  assign cpu_ignore_o      = fetch_end;
  assign prog_erase_o      = perase_q;
  assign prog_we_o         = pwe_q;
  assign busy_o            = ~idle;
  assign store_done_flag_o = done_q;
  assign ext_data_grant_o  = ext_data_req_i & code_protect_b_i & data_protect_fuse_b_i;
  assign ext_code_grant_o  = ext_code_req_i & code_protect_b_i;

  property p_unlock_zero;
    @(posedge clk_i) disable iff (!rst_b_i)
    reg_re_i && hit(reg_addr_i, `NVMC_A_UNLK) |=> reg_rdata_o == 8'h00;
  endproperty
  a_unlock_zero: assert property (p_unlock_zero) else $error("unlock register read nonzero");

  property p_ee_read;
    @(posedge clk_i) disable iff (!rst_b_i)
    ee_rd_go |=> datl_q == $past(ee_rd_byte) && !rd_q;
  endproperty
  a_ee_read: assert property (p_ee_read) else $error("data read not loaded next cycle");

  property p_permit_gate;
    @(posedge clk_i) disable iff (!rst_b_i)
    $rose(wr_q) |-> $past(permit_q);
  endproperty
  a_permit_gate: assert property (p_permit_gate) else $error("write started without permit");

  property p_unlock_seq;
    @(posedge clk_i) disable iff (!rst_b_i)
    $rose(wr_q) |-> $past(unlock_q) == UL_AA && st_q == ST_ERASE;
  endproperty
  a_unlock_seq: assert property (p_unlock_seq) else $error("write started without unlock");

  property p_done;
    @(posedge clk_i) disable iff (!rst_b_i)
    prog_end |=> !wr_q && done_q && idle;
  endproperty
  a_done: assert property (p_done) else $error("completion did not flag");

  property p_pwrt;
    @(posedge clk_i) disable iff (!rst_b_i)
    $rose(wr_q) && !tcode_q |-> !$past(pwrt_on);
  endproperty
  a_pwrt: assert property (p_pwrt) else $error("data write during power-up");

  property p_lock;
    @(posedge clk_i) disable iff (!rst_b_i)
    $rose(wr_q) && tcode_q |-> !$past(locked);
  endproperty
  a_lock: assert property (p_lock) else $error("write to locked block");

  property p_fetch;
    @(posedge clk_i) disable iff (!rst_b_i)
    code_rd_go |=> rd_q ##1 prog_rd_o ##1 !rd_q && datl_q == $past(prog_rdata_i[7:0]);
  endproperty
  a_fetch: assert property (p_fetch) else $error("code fetch slot wrong");

  property p_permit_hold;
    @(posedge clk_i) disable iff (!por_b_i)
    permit_q && !ctl_wr |=> permit_q;
  endproperty
  a_permit_hold: assert property (p_permit_hold) else $error("permit cleared by hardware");

  property p_run_on;
    @(posedge clk_i) disable iff (!rst_b_i)
    wr_q && !prog_end |=> wr_q;
  endproperty
  a_run_on: assert property (p_run_on) else $error("write aborted early");

  property p_fetch_addr;
    @(posedge clk_i) disable iff (!rst_b_i)
    prog_rd_o |-> prog_addr_o == code_addr;
  endproperty
  a_fetch_addr: assert property (p_fetch_addr) else $error("fetch used a stale address");

  property p_code_word;
    @(posedge clk_i) disable iff (!rst_b_i)
    fetch_end |=> {dath_q, datl_q} == $past(prog_rdata_i);
  endproperty
  a_code_word: assert property (p_code_word) else $error("fetched word not split into data registers");

  property p_code_target;
    @(posedge clk_i) disable iff (!rst_b_i)
    wr_go && code_q |=> taddr_q == $past(code_addr) && tdata_q == $past({dath_q, datl_q});
  endproperty
  a_code_target: assert property (p_code_target) else $error("code write target not latched");

  property p_ee_target;
    @(posedge clk_i) disable iff (!rst_b_i)
    wr_go && !code_q |=> taddr_q == {7'h00, $past(adrl_q)};
  endproperty
  a_ee_target: assert property (p_ee_target) else $error("data write address not from low register");

  property p_space_reset;
    @(posedge clk_i)
    !rst_b_i |-> !code_q;
  endproperty
  a_space_reset: assert property (p_space_reset) else $error("reset left code space selected");

  property p_clear_on_end;
    @(posedge clk_i) disable iff (!rst_b_i)
    $fell(wr_q) |-> $past(prog_end);
  endproperty
  a_clear_on_end: assert property (p_clear_on_end) else $error("write bit cleared before completion");

  property p_permit_por;
    @(posedge clk_i)
    !por_b_i |-> !permit_q;
  endproperty
  a_permit_por: assert property (p_permit_por) else $error("permit set during power-up");

  property p_abort_set;
    @(posedge clk_i) disable iff (!por_b_i)
    abort_set |=> abort_q;
  endproperty
  a_abort_set: assert property (p_abort_set) else $error("interrupted write not flagged");

  property p_erase_first;
    @(posedge clk_i) disable iff (!rst_b_i)
    erase_end && !tcode_q |=> ee_mem[taddr_q[7:0]] == `NVMC_ERASED;
  endproperty
  a_erase_first: assert property (p_erase_first) else $error("data byte not erased");

  property p_program_byte;
    @(posedge clk_i) disable iff (!rst_b_i)
    prog_end && !tcode_q |=> ee_mem[taddr_q[7:0]] == tdata_q[7:0];
  endproperty
  a_program_byte: assert property (p_program_byte) else $error("data byte not programmed");

  property p_wr_len;
    @(posedge clk_i) disable iff (!rst_b_i)
    wr_go || erase_end |=> cnt_q == WR_LIM;
  endproperty
  a_wr_len: assert property (p_wr_len) else $error("write phase length not loaded");

  property p_unlock_drop;
    @(posedge clk_i) disable iff (!rst_b_i)
    acc && !unl_wr |=> unlock_q == UL_IDLE;
  endproperty
  a_unlock_drop: assert property (p_unlock_drop) else $error("unlock progress kept across access");

  property p_datl_hold;
    @(posedge clk_i) disable iff (!rst_b_i)
    !ee_rd_go && !fetch_end && !(reg_we_i && hit(reg_addr_i, `NVMC_A_DATL)) |=> $stable(datl_q);
  endproperty
  a_datl_hold: assert property (p_datl_hold) else $error("low data changed without read or write");
endmodule // nvmc_top

//--- nvmc_top_test.sv
`include "nvmc_defs.svh"
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin mismatches++; \
  $display("Error %s expected %h seen %h", nm, ex, got); end end
module nvmc_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  import nvmc_pkg::*;
  localparam int WR = 4;
  localparam logic [2:0] AL = `NVMC_A_ADRL;
  localparam logic [2:0] AH = `NVMC_A_ADRH;
  localparam logic [2:0] DL = `NVMC_A_DATL;
  localparam logic [2:0] DH = `NVMC_A_DATH;
  localparam logic [2:0] CT = `NVMC_A_CTRL;
  localparam logic [2:0] UL = `NVMC_A_UNLK;
  localparam logic [2:0] FL = `NVMC_A_FLAG;
  typedef struct {logic [7:0] addr_v; logic [7:0] data_v;} nvmc_row_s;
  logic        clk_i, por_b_i, rst_b_i, reg_we_i, reg_re_i;
  logic        dfuse_b, cprot_b, dreq, creq, dgnt, cgnt;
  logic        prog_rd_o, cpu_ignore_o, busy_o, perase, pwe, done;
  logic [1:0]  lock;
  logic [2:0]  reg_addr_i;
  logic [7:0]  reg_wdata_i, reg_rdata_o;
  logic [13:0] prog_rdata_i, prog_wdata_o;
  logic [14:0] prog_addr_o, pwe_addr;
  int          mismatches = 0;
  int          checks_done = 0;
  int          cycles = 0;
  int          n;
  int          n_erase = 0;
  int          n_pgm = 0;
  // The last row stores a zero byte, so a write that erased but never programmed shows up.
  nvmc_row_s   rows [3] = '{'{8'h00, 8'hA5}, '{8'hFF, 8'h3C}, '{8'h7F, 8'h00}};

  nvmc_top #(.PWRT_CYCLES(20), .WR_CYCLES(WR)) nvmc_top_i (
    .clk_i(clk_i), .por_b_i(por_b_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o),
    .self_program_lock_i(lock), .data_protect_fuse_b_i(dfuse_b), .code_protect_b_i(cprot_b),
    .ext_data_req_i(dreq), .ext_code_req_i(creq), .ext_data_grant_o(dgnt), .ext_code_grant_o(cgnt),
    .prog_rdata_i(prog_rdata_i), .prog_addr_o(prog_addr_o), .prog_wdata_o(prog_wdata_o),
    .prog_rd_o(prog_rd_o), .prog_erase_o(perase), .prog_we_o(pwe), .cpu_ignore_o(cpu_ignore_o),
    .busy_o(busy_o), .store_done_flag_o(done));

  // Pulses are counted on the falling edge, where the registered outputs have settled.
  always @(negedge clk_i) begin
    if (perase === 1'b1) n_erase++;
    if (pwe === 1'b1) begin
      n_pgm++;
      pwe_addr = prog_addr_o;
    end
  end

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  task automatic summarize;
    if (mismatches == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      mismatches++;
      summarize();
    end
  end

  // Each access waits one edge first, so back-to-back calls never drive a strobe twice in one step.
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_we_i <= 1'b1;
    @(posedge clk_i);
    reg_we_i <= 1'b0;
  endtask

  task automatic rchk(input logic [2:0] a, input logic [7:0] ex);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_re_i <= 1'b1;
    @(posedge clk_i);
    reg_re_i <= 1'b0;
    #1;
    `CHK("reg_rdata_o", ex, reg_rdata_o)
  endtask

  task automatic start(input logic [7:0] c);
    wr(UL, `NVMC_KEY1);
    wr(UL, `NVMC_KEY2);
    wr(CT, c);
  endtask

  task automatic idle(output int cnt);
    cnt = 0;
    #1;
    while (busy_o !== 1'b0 && cnt < 100) begin
      cnt++;
      @(posedge clk_i);
      #1;
    end
  endtask

  initial begin
    por_b_i = 1'b0;
    rst_b_i = 1'b0;
    reg_addr_i = 3'h0;
    reg_wdata_i = 8'h00;
    reg_we_i = 1'b0;
    reg_re_i = 1'b0;
    lock = 2'h2;
    dfuse_b = 1'b1;
    cprot_b = 1'b0;
    dreq = 1'b1;
    creq = 1'b1;
    prog_rdata_i = 14'h2ABC;
    repeat (16) @(posedge clk_i);
    por_b_i <= 1'b1;
    rst_b_i <= 1'b1;
    wr(AL, 8'h10);
    wr(DL, 8'h99);
    wr(CT, 8'h04);
    start(8'h06);
    idle(n);
    `CHK("busy_cycles", 0, n)
    `CHK("ext_data_grant_o", 1'b0, dgnt)
    `CHK("ext_code_grant_o", 1'b0, cgnt)
    repeat (20) @(posedge clk_i);
    wr(AH, 8'h7F);
    dfuse_b <= 1'b0;
    foreach (rows[i]) begin
      wr(AL, rows[i].addr_v);
      wr(DL, rows[i].data_v);
      wr(CT, 8'h04);
      start(8'h06);
      wr(CT, 8'h00);
      idle(n);
      `CHK("busy_cycles", 2 * WR - 2, n)
      `CHK("store_done_flag_o", 1'b1, done)
      rchk(FL, 8'h01);
      wr(FL, 8'h00);
      rchk(CT, 8'h00);
      wr(DL, ~rows[i].data_v);
      wr(CT, 8'h01);
      rchk(DL, rows[i].data_v);
    end
    `CHK("prog_erase_o", 0, n_erase)
    wr(DL, 8'h5A);
    rchk(DL, 8'h5A);
    start(8'h06);
    idle(n);
    `CHK("busy_cycles", 0, n)
    wr(CT, 8'h04);
    wr(UL, `NVMC_KEY2);
    wr(UL, `NVMC_KEY1);
    wr(CT, 8'h06);
    idle(n);
    `CHK("busy_cycles", 0, n)
    wr(UL, `NVMC_KEY1);
    rchk(UL, 8'h00);
    wr(UL, `NVMC_KEY2);
    wr(CT, 8'h06);
    idle(n);
    `CHK("busy_cycles", 0, n)
    start(8'h06);
    @(posedge clk_i);
    rst_b_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rst_b_i <= 1'b1;
    rchk(CT, 8'h0C);
    wr(CT, 8'h8C);
    @(posedge clk_i);
    rst_b_i <= 1'b0;
    @(posedge clk_i);
    rst_b_i <= 1'b1;
    rchk(CT, 8'h0C);
    wr(AH, 8'h12);
    wr(AL, 8'h34);
    wr(CT, 8'h80);
    wr(CT, 8'h81);
    #1;
    `CHK("prog_addr_o", 15'h1234, prog_addr_o)
    @(posedge clk_i);
    #1;
    `CHK("prog_rd_o", 1'b1, prog_rd_o)
    `CHK("cpu_ignore_o", 1'b1, cpu_ignore_o)
    rchk(DL, 8'hBC);
    rchk(DH, 8'h2A);
    wr(CT, 8'h84);
    start(8'h86);
    #1;
    `CHK("prog_wdata_o", 14'h2ABC, prog_wdata_o)
    idle(n);
    `CHK("busy_cycles", 2 * WR, n)
    wr(AH, 8'h00);
    wr(AL, 8'h00);
    start(8'h86);
    idle(n);
    `CHK("busy_cycles", 0, n)
    `CHK("prog_erase_o", 1, n_erase)
    `CHK("prog_we_o", 1, n_pgm)
    `CHK("pwe_addr", 15'h1234, pwe_addr)
    wr(CT, 8'h81);
    @(posedge clk_i);
    cprot_b <= 1'b1;
    #1;
    `CHK("prog_addr_o", 15'h0000, prog_addr_o)
    `CHK("ext_data_grant_o", 1'b0, dgnt)
    `CHK("ext_code_grant_o", 1'b1, cgnt)
    summarize();
  end
endmodule // nvmc_top_test
